/* hw/eptpc_map.svh */
`ifndef EPTPC_MAP_SVH
`define EPTPC_MAP_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define EPTPC_PAGES 16
`define EPTPC_IDX_W 4
`define EPTPC_CPUS 4

// ------------------------------------------------------------
// Page type codes
// ------------------------------------------------------------
`define EPTPC_TYPE_REG 3'h0
`define EPTPC_TYPE_TCS 3'h1
`define EPTPC_TYPE_ENCLAVE_CONTROL_STRUCTURE 3'h2
`define EPTPC_TYPE_VA 3'h3
`define EPTPC_TYPE_TRIM 3'h4

// ------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------
`define EPTPC_OP_NONE 3'h0
`define EPTPC_OP_TYPE 3'h1
`define EPTPC_OP_RESTRICT 3'h2
`define EPTPC_OP_EXTEND 3'h3
`define EPTPC_OP_ACCEPT 3'h4
`define EPTPC_OP_TRACK 3'h5
`define EPTPC_OP_REMOVE 3'h6
`define EPTPC_OP_ALLOC 3'h7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define EPTPC_PERM_NONE 3'h0
`endif

/* hw/eptpc_pkg.sv */
`include "eptpc_map.svh"
package eptpc_pkg;
    typedef logic [2:0] eptpc_type_t;
    typedef logic [2:0] eptpc_perm_t;
    typedef logic [2:0] eptpc_op_t;
    typedef logic [`EPTPC_IDX_W-1:0] eptpc_idx_t;
    typedef enum logic [1:0] {
        EPTPC_TRK_IDLE = 2'b00,
        EPTPC_TRK_WAIT = 2'b01,
        EPTPC_TRK_DONE = 2'b10
    } eptpc_trk_t;
endpackage : eptpc_pkg

/* hw/eptpc_tracker.sv */
`include "eptpc_map.svh"
module eptpc_tracker
    import eptpc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Control.
    input wire logic arm,
    input wire logic start,
    input wire logic [`EPTPC_CPUS-1:0] cpu_exited,
    // Status.
    output logic done
);
    // ------------------------------------------------------------
    // Epoch tracking
    // ------------------------------------------------------------
    // An arm restarts the epoch so a change made after tracking began is never covered by it.
    eptpc_trk_t state;
    eptpc_trk_t next_state;
    logic [`EPTPC_CPUS-1:0] pending;
    logic [`EPTPC_CPUS-1:0] next_pending;
    logic [`EPTPC_CPUS-1:0] pend_left;

    always_comb begin
        pend_left = pending & ~cpu_exited;
        next_state = state;
        next_pending = pending;
        if (arm) begin
            next_state = EPTPC_TRK_IDLE;
            next_pending = '0;
        end else begin
            case (state)
                EPTPC_TRK_IDLE: begin
                    if (start) begin
                        next_state = EPTPC_TRK_WAIT;
                        next_pending = '1;
                    end
                end
                EPTPC_TRK_WAIT: begin
                    next_pending = pend_left;
                    if (pend_left == '0) begin
                        next_state = EPTPC_TRK_DONE;
                    end
                end
                EPTPC_TRK_DONE: begin
                    next_state = EPTPC_TRK_DONE;
                end
                default: begin
                    next_state = EPTPC_TRK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= EPTPC_TRK_IDLE;
            pending <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            pending <= next_pending;
            done <= (next_state == EPTPC_TRK_DONE);
        end
    end
endmodule : eptpc_tracker

/* hw/eptpc_ctl.sv */
`include "eptpc_map.svh"
module eptpc_ctl
    import eptpc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Leaf operation request.
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [`EPTPC_IDX_W-1:0] op_page,
    input wire logic [2:0] op_type,
    input wire logic [2:0] op_perm,
    // Logical processor exits.
    input wire logic [`EPTPC_CPUS-1:0] cpu_exited,
    // Enclave access check.
    input wire logic acc_valid,
    input wire logic [`EPTPC_IDX_W-1:0] acc_page,
    input wire logic [2:0] acc_rwx,
    input wire logic acc_tlb_hit,
    input wire logic [2:0] acc_tlb_perm,
    // Operation result.
    output logic op_done,
    output logic op_ok,
    // Access result.
    output logic acc_done,
    output logic acc_grant,
    output logic acc_fault,
    output logic tlb_flush,
    // Page state view.
    output logic [`EPTPC_PAGES-1:0] page_valid,
    output logic [`EPTPC_PAGES-1:0] page_pending
);
    // ------------------------------------------------------------
    // Page map storage
    // ------------------------------------------------------------
    logic [`EPTPC_PAGES-1:0] valid;
    logic [`EPTPC_PAGES-1:0] pend;
    logic [`EPTPC_PAGES-1:0] modified;
    eptpc_type_t ptype [`EPTPC_PAGES];
    eptpc_perm_t perm [`EPTPC_PAGES];
    logic [`EPTPC_PAGES-1:0] next_valid;
    logic [`EPTPC_PAGES-1:0] next_pend;
    logic [`EPTPC_PAGES-1:0] next_modified;
    eptpc_type_t next_ptype [`EPTPC_PAGES];
    eptpc_perm_t next_perm [`EPTPC_PAGES];

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    logic next_op_done;
    logic next_op_ok;
    logic next_acc_done;
    logic next_acc_grant;
    logic next_acc_fault;
    logic next_tlb_flush;

    // Tracking control.
    logic trk_arm;
    logic trk_start;
    logic trk_done;

    // One tracker serves every page; a change on any page restarts the epoch for all of them.
    eptpc_tracker u_tracker (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .arm(trk_arm),
        .start(trk_start),
        .cpu_exited(cpu_exited),
        .done(trk_done)
    );

    // Selected entries.
    logic sel_valid;
    logic sel_pend;
    logic sel_mod;
    eptpc_type_t sel_type;
    logic a_valid;
    eptpc_type_t a_type;
    eptpc_perm_t a_perm;
    logic op_hit;
    logic chg_type;
    logic chg_restrict;
    // Derived entry conditions, named once so the decode and the access check read alike.
    logic sel_trim;
    logic sel_trimmable;
    logic sel_accept_ok;
    logic sel_remove_ok;
    logic acc_blocked;
    logic acc_stale;
    logic acc_covered;

    assign sel_valid = valid[op_page];
    assign sel_pend = pend[op_page];
    assign sel_mod = modified[op_page];
    assign sel_type = ptype[op_page];
    assign a_valid = valid[acc_page];
    assign a_type = ptype[acc_page];
    assign a_perm = perm[acc_page];
    assign op_hit = op_valid;
    assign sel_trim = (sel_type == `EPTPC_TYPE_TRIM);
    assign sel_trimmable = (sel_type == `EPTPC_TYPE_REG) || (sel_type == `EPTPC_TYPE_TCS);
    // Accept waits for a finished epoch unless the entry is a fresh allocation that was never reachable.
    assign sel_accept_ok = sel_valid && (sel_pend || (sel_mod && trk_done));
    assign sel_remove_ok = sel_valid && !sel_mod;
    assign acc_blocked = !a_valid || (a_type == `EPTPC_TYPE_TRIM) || pend[acc_page];
    // A translation is stale when it lacks a right the request needs, whatever the map now allows.
    assign acc_stale = acc_tlb_hit && ((acc_rwx & ~acc_tlb_perm) != 3'h0);
    assign acc_covered = ((acc_rwx & ~a_perm) == 3'h0);

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    // A new type change or restriction arms a fresh tracking epoch.
    always_comb begin
        chg_type = 1'b0;
        chg_restrict = 1'b0;
        if (op_hit && sel_valid && sel_type != `EPTPC_TYPE_TRIM) begin
            if (op_code == `EPTPC_OP_TYPE
                && (sel_type == `EPTPC_TYPE_REG || sel_type == `EPTPC_TYPE_TCS)) begin
                chg_type = 1'b1;
            end
            if (op_code == `EPTPC_OP_RESTRICT) begin
                chg_restrict = 1'b1;
            end
        end
        trk_arm = chg_type | chg_restrict;
        trk_start = op_hit && (op_code == `EPTPC_OP_TRACK) && !trk_arm;
    end

    always_comb begin
        next_valid = valid;
        next_pend = pend;
        next_modified = modified;
        next_ptype = ptype;
        next_perm = perm;
        next_op_done = op_hit;
        next_op_ok = 1'b0;
        if (op_hit) begin
            case (op_code)
                `EPTPC_OP_TYPE: begin
                    if (chg_type) begin
                        next_ptype[op_page] = op_type;
                        next_modified[op_page] = 1'b1;
                        if (op_type == `EPTPC_TYPE_TCS || op_type == `EPTPC_TYPE_TRIM) begin
                            next_perm[op_page] = `EPTPC_PERM_NONE;
                        end
                        next_op_ok = 1'b1;
                    end
                end
                `EPTPC_OP_RESTRICT: begin
                    if (chg_restrict) begin
                        // Rights only narrow; the page stays reachable meanwhile.
                        next_perm[op_page] = perm[op_page] & op_perm;
                        next_modified[op_page] = 1'b1;
                        next_op_ok = 1'b1;
                    end
                end
                `EPTPC_OP_EXTEND: begin
                    if (sel_valid && !sel_trim) begin
                        next_perm[op_page] = perm[op_page] | op_perm;
                        next_op_ok = 1'b1;
                    end
                end
                `EPTPC_OP_ACCEPT: begin
                    // Accept is refused while any processor may still cache the old view.
                    if (sel_accept_ok) begin
                        next_pend[op_page] = 1'b0;
                        next_modified[op_page] = 1'b0;
                        next_op_ok = 1'b1;
                    end
                end
                `EPTPC_OP_TRACK: begin
                    next_op_ok = trk_start;
                end
                `EPTPC_OP_REMOVE: begin
                    // Removal frees the entry so a trimmed page can be reallocated.
                    if (sel_remove_ok) begin
                        next_valid[op_page] = 1'b0;
                        next_pend[op_page] = 1'b0;
                        next_op_ok = 1'b1;
                    end
                end
                `EPTPC_OP_ALLOC: begin
                    if (!sel_valid) begin
                        next_valid[op_page] = 1'b1;
                        next_pend[op_page] = 1'b1;
                        next_modified[op_page] = 1'b0;
                        next_ptype[op_page] = `EPTPC_TYPE_REG;
                        next_perm[op_page] = op_perm;
                        next_op_ok = 1'b1;
                    end
                end
                default: begin
                    next_op_ok = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Access check
    // ------------------------------------------------------------
    // A cached translation never grants by itself: a hit that covers the request still needs the map to allow it; one that does not is faulted.
    // A stale hit on an unblocked page is faulted and flushed rather than granted from the map, so the retry sees the new rights.
    always_comb begin
        next_acc_done = acc_valid;
        next_acc_grant = 1'b0;
        next_acc_fault = 1'b0;
        next_tlb_flush = 1'b0;
        if (acc_valid) begin
            if (acc_blocked) begin
                next_acc_fault = 1'b1;
            end else if (acc_stale) begin
                next_acc_fault = 1'b1;
                next_tlb_flush = 1'b1;
            end else if (acc_covered) begin
                next_acc_grant = 1'b1;
            end else begin
                next_acc_fault = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Type and rights live in arrays, so each entry is registered by a process of its own.
    genvar gi;
    generate
        for (gi = 0; gi < `EPTPC_PAGES; gi++) begin : g_entry
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    ptype[gi] <= `EPTPC_TYPE_REG;
                    perm[gi] <= `EPTPC_PERM_NONE;
                end else begin
                    ptype[gi] <= next_ptype[gi];
                    perm[gi] <= next_perm[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            valid <= '0;
            pend <= '0;
            modified <= '0;
        end else begin
            valid <= next_valid;
            pend <= next_pend;
            modified <= next_modified;
        end
    end

    // ------------------------------------------------------------
    // Operation answer registers
    // ------------------------------------------------------------
    // Answers are registered, so each stands for exactly the one cycle after its request.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            op_done <= 1'b0;
            op_ok <= 1'b0;
        end else begin
            op_done <= next_op_done;
            op_ok <= next_op_ok;
        end
    end

    // ------------------------------------------------------------
    // Access answer registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc_done <= 1'b0;
            acc_grant <= 1'b0;
            acc_fault <= 1'b0;
            tlb_flush <= 1'b0;
        end else begin
            acc_done <= next_acc_done;
            acc_grant <= next_acc_grant;
            acc_fault <= next_acc_fault;
            tlb_flush <= next_tlb_flush;
        end
    end

    // ------------------------------------------------------------
    // Page state view registers
    // ------------------------------------------------------------
    // The view shows the map as it stands after this edge, so it never lags an answer.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            page_valid <= '0;
            page_pending <= '0;
        end else begin
            page_valid <= next_valid;
            page_pending <= next_pend | next_modified;
        end
    end
endmodule : eptpc_ctl

/* sim/eptpc_ctl_props.sv */
`include "eptpc_map.svh"
module eptpc_ctl_props
    import eptpc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Requests.
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [`EPTPC_IDX_W-1:0] op_page,
    input wire logic acc_valid,
    input wire logic [2:0] acc_rwx,
    input wire logic acc_tlb_hit,
    input wire logic [2:0] acc_tlb_perm,
    // Results.
    input wire logic op_done,
    input wire logic op_ok,
    input wire logic acc_done,
    input wire logic acc_grant,
    input wire logic acc_fault,
    input wire logic tlb_flush,
    input wire logic [`EPTPC_PAGES-1:0] page_valid,
    input wire logic [`EPTPC_PAGES-1:0] page_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_type_inv;
        op_valid && op_code == `EPTPC_OP_TYPE && !page_valid[op_page] |=> op_done && !op_ok;
    endproperty
    a_type_inv: assert property (p_type_inv) else $error("type change on invalid page");
    property p_restr_inv;
        op_valid && op_code == `EPTPC_OP_RESTRICT && !page_valid[op_page] |=> op_done && !op_ok;
    endproperty
    a_restr_inv: assert property (p_restr_inv) else $error("restrict on invalid page");
    property p_ext_inv;
        op_valid && op_code == `EPTPC_OP_EXTEND && !page_valid[op_page] |=> op_done && !op_ok;
    endproperty
    a_ext_inv: assert property (p_ext_inv) else $error("extend on invalid page");
    property p_acc_np;
        op_valid && op_code == `EPTPC_OP_ACCEPT && !page_pending[op_page] |=> op_done && !op_ok;
    endproperty
    a_acc_np: assert property (p_acc_np) else $error("accept with nothing pending");
    property p_acc_ans;
        acc_valid |=> acc_done && $onehot({acc_grant, acc_fault});
    endproperty
    a_acc_ans: assert property (p_acc_ans) else $error("access answer");
    property p_stale;
        acc_valid && acc_tlb_hit && (acc_rwx & ~acc_tlb_perm) != 3'h0 |=> acc_fault && !acc_grant;
    endproperty
    a_stale: assert property (p_stale) else $error("stale translation granted");
    property p_flush;
        tlb_flush |-> acc_fault && $past(acc_tlb_hit);
    endproperty
    a_flush: assert property (p_flush) else $error("flush without stale hit");
    property p_remove;
        op_done && op_ok && $past(op_code) == `EPTPC_OP_REMOVE |-> !page_valid[$past(op_page)];
    endproperty
    a_remove: assert property (p_remove) else $error("removed page still valid");
endmodule : eptpc_ctl_props

bind eptpc_ctl eptpc_ctl_props i_props (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid),
    .op_code(op_code), .op_page(op_page), .acc_valid(acc_valid), .acc_rwx(acc_rwx),
    .acc_tlb_hit(acc_tlb_hit), .acc_tlb_perm(acc_tlb_perm), .op_done(op_done), .op_ok(op_ok),
    .acc_done(acc_done), .acc_grant(acc_grant), .acc_fault(acc_fault), .tlb_flush(tlb_flush),
    .page_valid(page_valid), .page_pending(page_pending));

/* sim/eptpc_sw_model.sv */
`include "eptpc_map.svh"
module eptpc_sw_model
    import eptpc_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Leaf operations.
    output logic op_valid,
    output logic [2:0] op_code,
    output logic [`EPTPC_IDX_W-1:0] op_page,
    output logic [2:0] op_type,
    output logic [2:0] op_perm,
    output logic [`EPTPC_CPUS-1:0] cpu_exited,
    // Enclave accesses.
    output logic acc_valid,
    output logic [`EPTPC_IDX_W-1:0] acc_page,
    output logic [2:0] acc_rwx,
    output logic acc_tlb_hit,
    output logic [2:0] acc_tlb_perm
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {op_valid, op_code, op_page, op_type, op_perm, cpu_exited} = '0;
        {acc_valid, acc_page, acc_rwx, acc_tlb_hit, acc_tlb_perm} = '0;
    end
    // The op and acc tasks drive just after a falling edge and return on the next one, so calls may run back to back.
    task automatic op(input logic [2:0] c, input logic [3:0] p, input logic [2:0] t, input logic [2:0] m);
        acc_valid = 1'b0;
        {op_valid, op_code, op_page, op_type, op_perm} = {1'b1, c, p, t, m};
        @(negedge ref_clk);
    endtask : op
    task automatic acc(input logic [3:0] p, input logic [2:0] r, input logic h, input logic [2:0] tp);
        op_valid = 1'b0;
        {acc_valid, acc_page, acc_rwx, acc_tlb_hit, acc_tlb_perm} = {1'b1, p, r, h, tp};
        @(negedge ref_clk);
    endtask : acc
    // Released page, rights and access-type fields show their inverse so a stale value is never read as fresh.
    task automatic idle(input int n);
        {op_valid, acc_valid} = 2'b00;
        {op_page, op_perm, acc_page, acc_rwx} = ~{op_page, op_perm, acc_page, acc_rwx};
        repeat (n) @(negedge ref_clk);
    endtask : idle
    // Interrupted processors leave the enclave, all at once or one per cycle.
    task automatic exits(input logic slow);
        {op_valid, acc_valid} = 2'b00;
        for (int i = 0; i < `EPTPC_CPUS; i++) begin
            cpu_exited = slow ? 4'h1 << i : 4'hf;
            @(negedge ref_clk);
        end
        cpu_exited = '0;
        @(negedge ref_clk);
    endtask : exits
endmodule : eptpc_sw_model

/* sim/enclave_page_trim_and_permission_ctl_test.sv */
`include "eptpc_map.svh"
module enclave_page_trim_and_permission_ctl_test
    import eptpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, op_valid, op_done, op_ok, acc_valid, acc_tlb_hit, acc_done, acc_grant, acc_fault, tlb_flush;
    logic [2:0] op_code, op_type, op_perm, acc_rwx, acc_tlb_perm, r;
    logic [`EPTPC_IDX_W-1:0] op_page, acc_page, pg;
    logic [`EPTPC_CPUS-1:0] cpu_exited;
    logic [`EPTPC_PAGES-1:0] page_valid, page_pending;
    logic op_q[$];
    logic [2:0] acc_q[$];
    int num_errors, comparisons;
    eptpc_sw_model i_sw (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code), .op_page(op_page),
        .op_type(op_type), .op_perm(op_perm), .cpu_exited(cpu_exited), .acc_valid(acc_valid),
        .acc_page(acc_page), .acc_rwx(acc_rwx), .acc_tlb_hit(acc_tlb_hit), .acc_tlb_perm(acc_tlb_perm));
    eptpc_ctl i_dut (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
        .op_page(op_page), .op_type(op_type), .op_perm(op_perm), .cpu_exited(cpu_exited),
        .acc_valid(acc_valid), .acc_page(acc_page), .acc_rwx(acc_rwx), .acc_tlb_hit(acc_tlb_hit),
        .acc_tlb_perm(acc_tlb_perm), .op_done(op_done), .op_ok(op_ok), .acc_done(acc_done),
        .acc_grant(acc_grant), .acc_fault(acc_fault), .tlb_flush(tlb_flush),
        .page_valid(page_valid), .page_pending(page_pending));
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic do_op(input logic [2:0] c, input logic [3:0] p, input logic [2:0] t, input logic [2:0] m,
                         input logic e);
        op_q.push_back(e);
        i_sw.op(c, p, t, m);
    endtask : do_op
    task automatic do_acc(input logic [3:0] p, input logic [2:0] rw, input logic h, input logic [2:0] tp,
                          input logic [2:0] e);
        acc_q.push_back(e);
        i_sw.acc(p, rw, h, tp);
    endtask : do_acc
    // Results are judged against the oldest outstanding note.
    always @(negedge ref_clk) begin
        if (op_done !== 1'b0) begin
            check({2'b00, op_ok}, {2'b00, op_q.size() ? op_q.pop_front() : 1'bx});
        end
        if (acc_done !== 1'b0) begin
            check({acc_grant, acc_fault, tlb_flush}, acc_q.size() ? acc_q.pop_front() : 3'hx);
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {num_errors, comparisons, nrst} = '0;
        void'($urandom(32'h7e2df008));
        pg = 4'(8 + $urandom % 8);
        r = 3'(1 + $urandom % 6);
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        for (int c = 1; c <= 6; c++) do_op(3'(c), pg, 3'h0, 3'h7, c == 5);
        do_op(`EPTPC_OP_ALLOC, 4'h3, 3'h0, 3'h7, 1'b1);
        do_acc(4'h3, 3'h1, 1'b0, 3'h0, 3'b010);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b1);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b0);
        do_op(`EPTPC_OP_RESTRICT, 4'h3, 3'h0, 3'h1, 1'b1);
        do_acc(4'h3, 3'h1, 1'b0, 3'h0, 3'b100);
        do_acc(4'h3, 3'h2, 1'b0, 3'h0, 3'b010);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b0);
        do_op(`EPTPC_OP_TRACK, 4'h3, 3'h0, 3'h0, 1'b1);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b0);
        i_sw.exits(1'b1);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b1);
        do_op(`EPTPC_OP_EXTEND, 4'h3, 3'h0, 3'h6, 1'b1);
        do_acc(4'h3, 3'h2, 1'b1, 3'h1, 3'b011);
        do_acc(4'h3, 3'h2, 1'b0, 3'h0, 3'b100);
        do_op(`EPTPC_OP_TYPE, 4'h3, `EPTPC_TYPE_TRIM, 3'h0, 1'b1);
        do_op(`EPTPC_OP_TRACK, 4'h3, 3'h0, 3'h0, 1'b1);
        i_sw.exits(1'b0);
        do_op(`EPTPC_OP_ACCEPT, 4'h3, 3'h0, 3'h0, 1'b1);
        do_acc(4'h3, 3'h1, 1'b0, 3'h0, 3'b010);
        for (int c = 1; c <= 3; c++) do_op(3'(c), 4'h3, `EPTPC_TYPE_REG, 3'h7, 1'b0);
        do_op(`EPTPC_OP_REMOVE, 4'h3, 3'h0, 3'h0, 1'b1);
        i_sw.idle(1);
        check({1'b0, page_valid[3], page_pending[3]}, 3'h0);
        do_op(`EPTPC_OP_ALLOC, 4'h3, 3'h0, 3'h7, 1'b1);
        do_op(`EPTPC_OP_ALLOC, 4'h7, 3'h0, r, 1'b1);
        do_op(`EPTPC_OP_ACCEPT, 4'h7, 3'h0, 3'h0, 1'b1);
        do_acc(4'h7, r, 1'b0, 3'h0, 3'b100);
        do_acc(4'h7, ~r, 1'b0, 3'h0, 3'b010);
        do_op(`EPTPC_OP_TYPE, 4'h7, `EPTPC_TYPE_TCS, 3'h0, 1'b1);
        do_op(`EPTPC_OP_TRACK, 4'h7, 3'h0, 3'h0, 1'b1);
        i_sw.exits(1'b1);
        do_op(`EPTPC_OP_ACCEPT, 4'h7, 3'h0, 3'h0, 1'b1);
        do_op(`EPTPC_OP_TYPE, 4'h7, `EPTPC_TYPE_TRIM, 3'h0, 1'b1);
        i_sw.idle(2);
        for (int i = 0; i < 20 && op_q.size() + acc_q.size() > 0; i++) @(negedge ref_clk);
        if (op_q.size() + acc_q.size() > 0) num_errors++;
        tally_and_finish();
    end
endmodule : enclave_page_trim_and_permission_ctl_test
